/* include/pdcap_consts.svh */
// Offsets, field positions and reset values of the device capability block
`ifndef PDCAP_CONSTS_SVH
`define PDCAP_CONSTS_SVH
`define PDCAP_DEVCAP_OFFSET 8'h48
`define PDCAP_RESET_VALUE 32'h00000001
`define PDCAP_SCALE_HI 27
`define PDCAP_SCALE_LO 26
`define PDCAP_VALUE_HI 25
`define PDCAP_VALUE_LO 18
`define PDCAP_MPS_CAP 3'h1
`define PDCAP_UNMAPPED_DATA 32'h00000000
`endif

/* include/pdcap_pkg.sv */
// Types of the device capability block
package pdcap_pkg;
  typedef logic [1:0] pdcap_scale_t;
  typedef logic [7:0] pdcap_value_t;
  typedef logic [31:0] pdcap_word_t;
  typedef enum logic [1:0] {
    PDCAP_IDLE = 2'b01,
    PDCAP_ANSWER = 2'b10
  } pdcap_state_e;
endpackage : pdcap_pkg

/* include/pdcap_limit_if.sv */
// Slot power limit carrier between capture and register bank
`timescale 1ns/1ps
interface pdcap_limit_if;
  logic [1:0] scale;
  logic [7:0] value;
  modport source (output scale, output value);
  modport sink (input scale, input value);
endinterface : pdcap_limit_if

/* src/pdcap_limit_capture.sv */
// Captures scale and value from a received slot power limit message
`timescale 1ns/1ps
`include "pdcap_consts.svh"
module pdcap_limit_capture (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic msg_valid_i,
  input wire logic [1:0] msg_scale_i,
  input wire logic [7:0] msg_value_i,
  pdcap_limit_if.source lim
);
  import pdcap_pkg::*;
  pdcap_scale_t scale_r;
  pdcap_value_t value_r;

  // ----------------------------------------
  // Capture registers, reset to zero
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scale_r <= 2'h0;
      value_r <= 8'h00;
    end else if (msg_valid_i) begin
      scale_r <= msg_scale_i;
      value_r <= msg_value_i;
    end
  end

  assign lim.scale = scale_r;
  assign lim.value = value_r;

  load_msg_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    msg_valid_i |=> (scale_r == $past(msg_scale_i)) && (value_r == $past(msg_value_i)))
    else $error("slot power limit not captured");
  hold_msg_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !msg_valid_i |=> $stable(value_r) && $stable(scale_r))
    else $error("slot power limit changed without message");
endmodule : pdcap_limit_capture

/* src/pdcap_device_cap.sv */
// Device capability register bank on an Avalon-MM slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pdcap_consts.svh"
// Summary of operation
// - 32-bit read-only word, resets to one
// - Two-bit power scale at 27:26, reset zero
// - Limit message loads scale and value
// - Eight-bit power value at 25:18, reset zero
// - Deep sleep latency 11:9 reads zero
// - Standby latency 8:6 reads zero
// - Wide tag bit 5 reads zero
// - Extra function tag 4:3 reads zero
// - Max payload field 2:0 reads 001
module pdcap_device_cap (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic msg_valid_i,
  input wire logic [1:0] msg_scale_i,
  input wire logic [7:0] msg_value_i,
  output pdcap_pkg::pdcap_word_t device_capability_o
);
  import pdcap_pkg::*;

  // Capture carrier, handshake state and output flops
  pdcap_limit_if lim ();
  pdcap_state_e state_r;
  pdcap_state_e state_nxt;
  pdcap_word_t readdata_r;
  pdcap_word_t cap_r;
  logic wait_r;

  // ----------------------------------------
  // Slot power limit capture
  // ----------------------------------------
  // The only stored fields; everything else is wired
  pdcap_limit_capture u_capture (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .msg_valid_i(msg_valid_i),
    .msg_scale_i(msg_scale_i),
    .msg_value_i(msg_value_i),
    .lim(lim)
  );

  // ----------------------------------------
  // Word assembly and decode
  // ----------------------------------------
  // Constant fields are wired; only the power limit is stored
  wire [3:0] rsvd_top_field = 4'h0;
  wire [1:0] slot_power_scale_field = lim.scale;
  wire [7:0] slot_power_value_field = lim.value;
  wire [5:0] rsvd_mid_field = 6'h00;
  // Low-power states unused, so no exit latency tolerated
  wire [2:0] deep_sleep_exit_latency_field = 3'h0;
  wire [2:0] standby_exit_latency_field = 3'h0;
  // Tags stay five bits: no wide tags, no extra functions
  wire wide_tag_capable_bit = 1'b0;
  wire [1:0] extra_function_tag_field = 2'h0;
  wire [2:0] max_payload_capability_field = `PDCAP_MPS_CAP;
  wire pdcap_word_t cap_word = {rsvd_top_field, slot_power_scale_field, slot_power_value_field,
                                rsvd_mid_field, deep_sleep_exit_latency_field, standby_exit_latency_field,
                                wide_tag_capable_bit, extra_function_tag_field, max_payload_capability_field};

  // ----------------------------------------
  // Address decode and request qualification
  // ----------------------------------------
  // Only the one word is mapped; other addresses read zero
  wire hit = (avs_address_i == `PDCAP_DEVCAP_OFFSET);
  wire req = avs_read_i | avs_write_i;
  // Taken only in idle, so a held request is not taken twice
  wire take = (state_r == PDCAP_IDLE) && req;
  wire take_read = (state_r == PDCAP_IDLE) && avs_read_i;
  wire take_write = (state_r == PDCAP_IDLE) && avs_write_i;
  // Writes are accepted and dropped: the word has no write path
  wire pdcap_word_t read_word = hit ? cap_word : `PDCAP_UNMAPPED_DATA;

  // ----------------------------------------
  // Bus handshake: one wait cycle, then answer
  // ----------------------------------------
  // Next state: idle takes a request, answer returns to idle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PDCAP_IDLE: begin
        if (req) begin
          state_nxt = PDCAP_ANSWER;
        end
      end
      PDCAP_ANSWER: begin
        state_nxt = PDCAP_IDLE;
      end
      // Illegal one-hot codes fall back to idle
      default: begin
        state_nxt = PDCAP_IDLE;
      end
    endcase
  end

  // Handshake state; waitrequest low only in the answer cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= PDCAP_IDLE;
      wait_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      wait_r <= !take;
    end
  end

  // Read data register; holds until the next read is taken
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      readdata_r <= 32'h00000000;
    end else if (take_read) begin
      readdata_r <= read_word;
    end
  end

  // Registered copy of the word, one edge behind it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_r <= `PDCAP_RESET_VALUE;
    end else begin
      cap_r <= cap_word;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output comes straight from a flop
  assign avs_readdata_o = readdata_r;
  assign avs_waitrequest_o = wait_r;
  assign device_capability_o = cap_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Reset value, both power limit fields after a message, and fixed fields that never move
  reset_value_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> cap_r == `PDCAP_RESET_VALUE)
    else $error("capability word wrong after reset");
  scale_field_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    msg_valid_i |=> ##1 cap_r[27:26] == $past(msg_scale_i, 2))
    else $error("scale field not reported");
  value_field_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    msg_valid_i |=> ##1 cap_r[25:18] == $past(msg_value_i, 2))
    else $error("value field not reported");
  latency_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cap_r[11:9] == 3'h0)
    else $error("deep sleep latency not zero");
  standby_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cap_r[8:6] == 3'h0)
    else $error("standby latency not zero");
  tag_bits_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cap_r[5] == 1'b0)
    else $error("wide tag bit not zero");
  phantom_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cap_r[4:3] == 2'h0)
    else $error("phantom field not zero");
  payload_cap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cap_r[2:0] == `PDCAP_MPS_CAP)
    else $error("payload field not 001");
  reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cap_r[31:28] == 4'h0 && cap_r[17:12] == 6'h00)
    else $error("reserved bits not zero");
  // Both captured fields restart from zero
  reset_fields_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> cap_word[27:18] == 10'h000)
    else $error("power limit fields not zero after reset");

  // ----------------------------------------
  // Bus handshake checks
  // ----------------------------------------
  // Every request answered after exactly one wait cycle
  read_answer_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_r == PDCAP_IDLE && avs_read_i && hit) |=> !avs_waitrequest_o && avs_readdata_o == $past(cap_word))
    else $error("read answer wrong");
  write_ignored_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (avs_write_i && !msg_valid_i) |=> $stable(lim.value) && $stable(lim.scale))
    else $error("write altered capability");
  write_answer_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    take_write |=> !avs_waitrequest_o)
    else $error("write not answered");
  answer_once_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  idle_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_r == PDCAP_IDLE && !req) |=> avs_waitrequest_o)
    else $error("waitrequest low without request");
  read_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !take_read |=> $stable(avs_readdata_o))
    else $error("read data changed without read");
  unmapped_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (take_read && !hit) |=> avs_readdata_o == `PDCAP_UNMAPPED_DATA)
    else $error("unmapped read not zero");
  // Writes complete but leave no trace
  write_dropped_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (take_write && hit && avs_writedata_i != 32'h00000000 && !msg_valid_i) |=> cap_word == $past(cap_word))
    else $error("write data reached capability word");
  // Output copy lags the word by one edge
  copy_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    device_capability_o == $past(cap_word))
    else $error("capability output not a copy of the word");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  // Reads, writes, partial writes, messages, unmapped reads
  read_cap_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) avs_read_i && hit && !avs_waitrequest_o);
  write_cap_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) avs_write_i && hit && !avs_waitrequest_o);
  msg_load_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) msg_valid_i && msg_scale_i == 2'h3);
  unmapped_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) avs_read_i && !hit && !avs_waitrequest_o);
  partial_write_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) take_write && hit && avs_byteenable_i != 4'hf);
endmodule : pdcap_device_cap

/* verif/pdcap_msg_src.sv */
// Upstream port model sending slot power limit messages
`timescale 1ns/1ps
module pdcap_msg_src (
  input wire logic mclk_i,
  output logic msg_valid_o = 1'b0,
  output logic [1:0] msg_scale_o = 2'h0,
  output logic [7:0] msg_value_o = 8'h00
);
  // One-cycle pulse; contents inverted after it so stale data cannot pass
  task automatic send(input logic [1:0] s, input logic [7:0] v);
    msg_valid_o <= 1'b1;
    msg_scale_o <= s;
    msg_value_o <= v;
    @(posedge mclk_i);
    msg_valid_o <= 1'b0;
    msg_scale_o <= ~s;
    msg_value_o <= ~v;
  endtask : send
endmodule : pdcap_msg_src

/* verif/pcie_device_capability_reg_tb.sv */
// Self-checking bench of the device capability register bank
`timescale 1ns/1ps
`include "pdcap_consts.svh"
module pcie_device_capability_reg_tb;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o, device_capability_o, q, e;
  logic avs_waitrequest_o, msg_valid_i;
  logic [1:0] msg_scale_i;
  logic [7:0] msg_value_i;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  // 200 MHz clock
  always #2.5 mclk_i = ~mclk_i;
  pdcap_device_cap u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .msg_valid_i(msg_valid_i), .msg_scale_i(msg_scale_i),
    .msg_value_i(msg_value_i), .device_capability_o(device_capability_o));
  pdcap_msg_src u_src (.mclk_i(mclk_i), .msg_valid_o(msg_valid_i), .msg_scale_o(msg_scale_i),
    .msg_value_o(msg_value_i));
  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, g, x);
    end
  endtask : chk
  // Held until waitrequest is seen low; one idle edge keeps requests apart
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask : acc
  task automatic close_out();
    $display("TB: %0d checks, %0d failures", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // Hang guard, well above the fifty-odd cycles the tests need
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 1000) begin
      failures++;
      $display("Error at %0t: timeout", $time);
      close_out();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    acc(1'b0, `PDCAP_DEVCAP_OFFSET, 32'h0, q);
    chk(q, `PDCAP_RESET_VALUE);
    chk(device_capability_o, 32'h00000001);
    avs_byteenable_i <= 4'h5;
    acc(1'b1, 8'h48, 32'hffffffff, q);
    acc(1'b0, 8'h48, 32'h0, q);
    chk(q, 32'h00000001);
    acc(1'b1, 8'h4c, 32'hffffffff, q);
    acc(1'b0, 8'h4c, 32'h0, q);
    chk(q, `PDCAP_UNMAPPED_DATA);
    $display("TB: reset value and write test done");
    // Every scale code, value from all ones down to zero
    for (int s = 0; s < 4; s++) begin
      e = {4'h0, 2'(s), 8'(255 - 85 * s), 15'h0, `PDCAP_MPS_CAP};
      u_src.send(2'(s), 8'(255 - 85 * s));
      repeat (2) @(posedge mclk_i);
      chk(device_capability_o, e);
      acc(1'b0, 8'h48, 32'h0, q);
      chk(q, e);
    end
    acc(1'b1, 8'h48, 32'h0, q);
    acc(1'b0, 8'h48, 32'h0, q);
    chk(q, e);
    $display("TB: slot power message test done");
    rst_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    acc(1'b0, 8'h48, 32'h0, q);
    chk(q, 32'h00000001);
    $display("TB: mid-run reset test done");
    close_out();
  end
endmodule : pcie_device_capability_reg_tb
